// ---- bench/sac_analog_model.sv ----
/* Analog side: channel levels, amplifier, sample-hold and comparator.
   Assumes levels in result LSB units; above 3ffh is over range. */
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model (
	// Clock
	input wire logic pclk,
	// Converter controls
	input wire logic [9:0] trial_code,
	input wire logic sample_hold,
	input wire logic converter_power_on,
	input wire logic [2:0] input_channel_select,
	input wire logic amplifier_select,
	input wire logic amplifier_zero_calibrate,
	input wire logic [10:0] level [8],
	// Comparator
	output logic comparator_high
);
	logic [13:0] v;
	logic [13:0] held = 14'h0;
	logic junk = 1'b0;
	// Input mux, zero tie and gain of eight
	always_comb begin
		v = amplifier_zero_calibrate ? 14'h0 : {3'h0, level[input_channel_select]};
		if (amplifier_select)
			v = v << 3;
	end
	// Hold the sample; unpowered output wanders
	always @(posedge pclk) begin
		if (sample_hold)
			held <= v;
		junk <= ~junk;
	end
	// Half-LSB offset so a level equal to the trial keeps the bit
	assign comparator_high = converter_power_on ? ({held, 1'b1} > {4'h0, trial_code, 1'b0}) : junk;
endmodule
`default_nettype wire

// ---- bench/sac_monitor.sv ----
/* Checker for the converter control block, ports only.
   Assumes it is bound to sac_top, one clock, async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module sac_monitor (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Converter side
	input wire logic halt_mode,
	input wire logic [9:0] trial_code,
	input wire logic sample_hold,
	input wire logic converter_power_on,
	input wire logic amplifier_power,
	input wire logic end_of_conversion
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase of a high result read
	wire rd_hi = psel && penable && !pwrite && paddr == 12'h0d4;
	halt_off_a: assert property (halt_mode |-> !converter_power_on)
		else $error("converter powered in halt");
	amp_power_a: assert property (amplifier_power == converter_power_on)
		else $error("amplifier power differs from converter power");
	eoc_hold_a: assert property (end_of_conversion && !rd_hi |=> end_of_conversion)
		else $error("end flag dropped without high read");
	eoc_clear_a: assert property (rd_hi && end_of_conversion && $past(end_of_conversion)
		|=> !end_of_conversion || (sample_hold && !$past(sample_hold, 3)))
		else $error("end flag not cleared by high read");
	eoc_set_a: assert property ($rose(end_of_conversion) && $past(converter_power_on)
		|-> sample_hold && !$past(sample_hold, 2))
		else $error("end flag rose outside conversion end");
	off_idle_a: assert property (!converter_power_on ##1 !converter_power_on ##1 !converter_power_on
		|-> !$rose(end_of_conversion))
		else $error("conversion finished while off");
	first_trial_a: assert property ($fell(sample_hold) && converter_power_on |-> trial_code == 10'h200)
		else $error("first trial code wrong");
	slverr_a: assert property (psel && penable |-> pslverr == !(paddr inside {12'h0d0, 12'h0d4, 12'h0d8}))
		else $error("error response wrong");
	low_zero_a: assert property (psel && penable && !pwrite && paddr == 12'h0d8 |-> prdata[7:5] == 3'h0)
		else $error("low register top bits not zero");
endmodule
bind sac_top sac_monitor u_sac_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pslverr, .halt_mode, .trial_code, .sample_hold, .converter_power_on, .amplifier_power, .end_of_conversion);
`default_nettype wire

// ---- bench/tb_top.sv ----
/* Self-checking bench: APB register tasks and conversion sequences.
   Assumes sac_top zero wait states and the analog model beside it. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [11:0] AC = 12'h0d0, AH = 12'h0d4, AL = 12'h0d8;
	localparam int stabilization_interval = 16; // Settling wait after halt, in cycles
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, halt_mode = 0, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, lo;
	logic [9:0] res;
	logic [10:0] level [8] = '{11'h155, 11'h2aa, 11'h001, 11'h3fe, 11'h200, 11'h7ff, 11'h000, 11'h0aa};
	wire [31:0] prdata;
	wire [9:0] trial_code;
	wire [2:0] input_channel_select;
	wire pready, pslverr, comparator_high, sample_hold, converter_power_on, amplifier_power;
	wire amplifier_select, amplifier_zero_calibrate, end_of_conversion;
	int bad_count = 0, comparisons = 0, cyc = 0, n;
	int dv [4] = '{2, 1, 4, 4};
	sac_top u_sac_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.halt_mode(halt_mode), .comparator_high(comparator_high), .trial_code(trial_code),
		.sample_hold(sample_hold), .converter_power_on(converter_power_on), .amplifier_power(amplifier_power),
		.input_channel_select(input_channel_select), .amplifier_select(amplifier_select),
		.amplifier_zero_calibrate(amplifier_zero_calibrate), .end_of_conversion(end_of_conversion));
	sac_analog_model u_sac_analog_model (.pclk(pclk), .trial_code(trial_code), .sample_hold(sample_hold),
		.converter_power_on(converter_power_on), .input_channel_select(input_channel_select),
		.amplifier_select(amplifier_select), .amplifier_zero_calibrate(amplifier_zero_calibrate),
		.level(level), .comparator_high(comparator_high));
	// Clock and hang guard
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			final_report;
		end
	end
	task final_report;
		if (bad_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer; request held until pready is seen
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Stop, clear the flag, start, poll, read low then high
	task conv(input logic [7:0] c);
		apb(1, AC, c & 8'hdf);
		@(negedge pclk);
		chk({converter_power_on, amplifier_power}, 0);
		apb(0, AH, 0);
		apb(1, AC, c);
		rd = 0;
		for (int i = 0; i < 300 && rd[7] !== 1'b1; i++) apb(0, AC, 0);
		chk(rd[7], 1);
		apb(0, AL, 0);
		lo = rd;
		apb(0, AH, 0);
		res = {rd[7:0], lo[1:0]};
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(0, AC, 0); chk(rd, 0);
		apb(0, AL, 0); chk(rd & 32'hfc, 0);
		apb(0, 12'h0dc, 0); chk(err, 1);
		apb(1, AC, 8'h80); apb(0, AC, 0); chk(rd, 0);
		apb(1, AL, 8'hff); apb(0, AL, 0); chk(rd & 32'hfc, 32'h1c);
		chk({amplifier_zero_calibrate, amplifier_select}, 2'b11);
		apb(1, AL, 0);
		// Every channel at full speed, with both range limits
		for (int c = 0; c < 7; c++) begin
			conv(8'h60 | c[7:0]); chk(res, level[c] > 11'h3ff ? 10'h3ff : level[c][9:0]);
			chk(input_channel_select, c[2:0]);
			apb(0, AC, 0); chk(rd, 8'h60 | c[7:0]);
		end
		// Divider settings timed from power-on to the flag
		for (int k = 0; k < 4; k++) begin
			apb(1, AC, 0); apb(0, AH, 0); apb(1, AL, k[1] ? 8'h08 : 8'h00);
			apb(1, AC, k[0] ? 8'h60 : 8'h20);
			for (n = 0; n < 1000 && end_of_conversion !== 1'b1; n++) @(posedge pclk);
			chk(n >= 44 * dv[k] && n <= 46 * dv[k] + 4, 1);
		end
		// Amplifier after the slow clock is chosen, then zero tie
		level[0] <= 11'h040;
		apb(1, AL, 8'h0c); conv(8'h20); chk(res, 10'h200);
		apb(1, AH, 8'h55); apb(0, AH, 0); chk(rd, 32'h80);
		apb(1, AL, 8'h1c); conv(8'h20); chk(res, 10'h000);
		// Halt stops conversions; release resumes them
		@(posedge pclk) halt_mode <= 1;
		apb(0, AH, 0);
		repeat (300) @(posedge pclk);
		chk({end_of_conversion, converter_power_on}, 0);
		halt_mode <= 0;
		repeat (stabilization_interval) @(posedge pclk);
		for (n = 0; n < 1000 && end_of_conversion !== 1'b1; n++) @(posedge pclk);
		chk(end_of_conversion, 1);
		// Eight-bit read: flag seen, high register only, flag cleared
		apb(0, AH, 0); chk(rd, 0);
		@(negedge pclk); chk(end_of_conversion, 0);
		final_report;
	end
endmodule
`default_nettype wire

// ---- verilog/sac_consts.vh ----
/*
 * Constants for the converter control block: register indices, field positions,
 * reset values and conversion timing counts.
 * Assumes it is included by the block's design files and needs nothing else.
 */
// Notes on behaviour
// - End-of-conversion flag, control bit 7, sets at conversion end, clears on high result read.
// - Setting the power-on bit starts back-to-back conversions of the selected channel.
// - Clearing the power-on bit switches off converter and amplifier; no conversions.
// - Channel field bits 2:0 routes input 0 through 6 to the converter.
// - High result register holds bits 9:2; low register bits 1:0 hold bits 1:0.
// - Input above high reference reads FFh high, 03h low, no overflow flag.
// - Input below low reference reads all zero in both result registers.
// - Converter clock: both clear CPU/2, speed alone CPU/1, slow set CPU/4.
// - Calibration bit ties amplifier input to 0V so the result shows offset.
// - Low register bits 7:5 always read zero.
// - Reset clears control register and low register bits 7:2; results undefined.
// - Wait mode leaves conversion running; halt mode disables the converter.
// - Selected amplifier multiplies input by eight; range zero to supply over eight.
// - Amplifier is powered with the power-on bit; no extra start-up delay.
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// Register indices; byte address is four times the index
`define SAC_IDX_CTRL 8'h34
`define SAC_IDX_RES_HIGH 8'h35
`define SAC_IDX_RES_LOW 8'h36
`define SAC_ADDR_W 12

// Control register fields
`define SAC_CTRL_EOC 7
`define SAC_CTRL_SPEED 6
`define SAC_CTRL_PON 5
`define SAC_CTRL_CH_HI 2
`define SAC_CTRL_RESET 8'h00

// Low register fields
`define SAC_LOW_AMPLIFIER_ZERO_CALIBRATE 4
`define SAC_LOW_SLOW 3
`define SAC_LOW_AMPLIFIER_SELECT 2
`define SAC_LOW_CFG_RESET 3'h0

// Result width and conversion timing in converter clocks
`define SAC_RES_BITS 10
`define SAC_SAMPLE_TICKS 3'h4
`define SAC_TICKS_PER_BIT 3'h4

// Divider terminal counts for CPU/1, CPU/2, CPU/4
`define SAC_DIV1_LAST 2'h0
`define SAC_DIV2_LAST 2'h1
`define SAC_DIV4_LAST 2'h3

`endif

// ---- verilog/sac_sar.v ----
/*
 * Successive-approximation sequencer: sample phase, then ten trial bits,
 * most significant first, one trial per fixed number of converter clocks.
 * Assumes a one-cycle tick at the converter clock rate and a comparator level
 * already synchronised to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"

module sac_sar (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control
	input wire tick,
	input wire run,
	input wire cmp_high,
	// Analog side
	output reg [`SAC_RES_BITS-1:0] trial_code,
	output reg sample,
	// Result
	output reg done,
	output reg [`SAC_RES_BITS-1:0] result
);

	localparam ST_IDLE = 2'h0;
	localparam ST_SAMPLE = 2'h1;
	localparam ST_TRIAL = 2'h2;

	reg [1:0] state;
	reg [2:0] cnt;
	reg [3:0] bit_idx;
	wire [`SAC_RES_BITS-1:0] bit_mask;
	wire [`SAC_RES_BITS-1:0] kept_code;

	// Keep the trial bit only when the input sits at or above the trial level
	assign bit_mask = 10'h001 << bit_idx;
	assign kept_code = cmp_high ? trial_code : (trial_code & ~bit_mask);

	// Sequencer; an input over range keeps every bit, under range drops every bit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			cnt <= 3'h0;
			bit_idx <= 4'h0;
			trial_code <= 10'h000;
			sample <= 1'b0;
			done <= 1'b0;
			result <= 10'h000;
		end else if (!run) begin
			state <= ST_IDLE;
			cnt <= 3'h0;
			trial_code <= 10'h000;
			sample <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
			ST_IDLE: begin
				state <= ST_SAMPLE;
				cnt <= 3'h0;
				sample <= 1'b1;
			end
			ST_SAMPLE: begin
				if (tick) begin
					if (cnt == `SAC_SAMPLE_TICKS - 3'h1) begin
						state <= ST_TRIAL;
						cnt <= 3'h0;
						sample <= 1'b0;
						bit_idx <= 4'h9;
						trial_code <= 10'h200;
					end else begin
						cnt <= cnt + 3'h1;
					end
				end
			end
			ST_TRIAL: begin
				if (tick) begin
					if (cnt == `SAC_TICKS_PER_BIT - 3'h1) begin
						cnt <= 3'h0;
						if (bit_idx == 4'h0) begin
							result <= kept_code;
							done <= 1'b1;
							state <= ST_SAMPLE;
							sample <= 1'b1;
							trial_code <= 10'h000;
						end else begin
							trial_code <= kept_code | (bit_mask >> 1);
							bit_idx <= bit_idx - 4'h1;
						end
					end else begin
						cnt <= cnt + 3'h1;
					end
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- verilog/sac_top.v ----
/*
 * Converter control block: APB register slave, converter clock divider,
 * power, channel and amplifier controls, result registers and the
 * end-of-conversion flag with its read-to-clear behaviour.
 * Assumes an analog macro that follows the trial code and returns a
 * comparator level from outside the clock domain, and a halt level from
 * logic on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"

module sac_top (
	// Clock and reset
	input wire pclk,
	input wire presetn,

	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`SAC_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,

	// Low-power mode from the clock controller
	input wire halt_mode,

	// Analog converter side
	input wire comparator_high,
	output wire [`SAC_RES_BITS-1:0] trial_code,
	output wire sample_hold,
	output wire converter_power_on,
	output wire amplifier_power,
	output wire [2:0] input_channel_select,
	output wire amplifier_select,
	output wire amplifier_zero_calibrate,

	// Status for the rest of the chip
	output wire end_of_conversion
);

	// Control register fields
	reg eoc;
	reg speed;
	reg power_on;
	reg [2:0] channel;

	// Low register configuration fields
	reg amp_cal;
	reg slow;
	reg amp_sel;

	// Result held for software
	reg [`SAC_RES_BITS-1:0] result;

	// Bus decode
	wire [7:0] reg_index;
	wire addr_aligned;
	wire hit_ctrl;
	wire hit_high;
	wire hit_low;
	wire hit_any;

	// Transfer phases and register strobes
	wire setup_phase;
	wire access_phase;
	wire wr_ctrl;
	wire wr_low;
	wire rd_high;
	wire rd_setup;

	// Read data from the addressed register, before capture
	reg [7:0] next_rdata;

	// Readable words of the three registers
	wire [7:0] ctrl_word;
	wire [7:0] high_word;
	wire [7:0] low_word;

	// Write data fields of the control register
	wire wr_speed;
	wire wr_power_on;
	wire [2:0] wr_channel;

	// Write data fields of the low register
	wire wr_amp_cal;
	wire wr_slow;
	wire wr_amp_sel;

	// A conversion that lands after the read data was captured
	reg done_late;

	// Flag set and clear terms
	wire eoc_set;
	wire eoc_clear;

	// Converter clock divider
	reg [1:0] div_cnt;
	reg [1:0] div_last;
	wire conv_tick;

	// Converter run enable
	wire run;

	// Comparator synchroniser
	reg cmp_meta;
	reg cmp_sync;

	// Sequencer outputs
	wire seq_done;
	wire [`SAC_RES_BITS-1:0] seq_result;

	// Address decode; the low two bits and upper bits must be zero
	assign addr_aligned = (paddr[1:0] == 2'h0) && (paddr[`SAC_ADDR_W-1:10] == 2'h0);
	assign reg_index = paddr[9:2];
	assign hit_ctrl = addr_aligned && (reg_index == `SAC_IDX_CTRL);
	assign hit_high = addr_aligned && (reg_index == `SAC_IDX_RES_HIGH);
	assign hit_low = addr_aligned && (reg_index == `SAC_IDX_RES_LOW);
	assign hit_any = hit_ctrl || hit_high || hit_low;

	// Transfer phases
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access_phase && !hit_any;

	// Register strobes taken at the completing edge
	assign wr_ctrl = access_phase && pwrite && hit_ctrl;
	assign wr_low = access_phase && pwrite && hit_low;
	assign rd_high = access_phase && !pwrite && hit_high;

	// Read data is loaded at the setup edge of a read
	assign rd_setup = setup_phase && !pwrite;

	// Write data fields picked from the low byte of the bus
	assign wr_speed = pwdata[`SAC_CTRL_SPEED];
	assign wr_power_on = pwdata[`SAC_CTRL_PON];
	assign wr_channel = pwdata[`SAC_CTRL_CH_HI:0];
	assign wr_amp_cal = pwdata[`SAC_LOW_AMPLIFIER_ZERO_CALIBRATE];
	assign wr_slow = pwdata[`SAC_LOW_SLOW];
	assign wr_amp_sel = pwdata[`SAC_LOW_AMPLIFIER_SELECT];

	// Control register; flag bit is not writable
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed <= 1'b0;
			power_on <= 1'b0;
			channel <= 3'h0;
		end else if (wr_ctrl) begin
			speed <= wr_speed;
			power_on <= wr_power_on;
			channel <= wr_channel;
		end
	end

	// Low register configuration bits; result bits are not writable
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amp_cal <= 1'b0;
			slow <= 1'b0;
			amp_sel <= 1'b0;
		end else if (wr_low) begin
			amp_cal <= wr_amp_cal;
			slow <= wr_slow;
			amp_sel <= wr_amp_sel;
		end
	end

	// Remember whether a conversion finished on the setup edge of a transfer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_late <= 1'b0;
		end else if (setup_phase) begin
			done_late <= seq_done;
		end else if (!psel) begin
			done_late <= 1'b0;
		end
	end

	// Flag terms; a read that captured stale data does not clear the flag
	assign eoc_set = seq_done;
	assign eoc_clear = rd_high && !done_late;

	// End-of-conversion flag; a finishing conversion wins over the read clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eoc <= 1'b0;
		end else if (eoc_set) begin
			eoc <= 1'b1;
		end else if (eoc_clear) begin
			eoc <= 1'b0;
		end
	end

	// Result copy taken in the same cycle the flag sets
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= 10'h000;
		end else if (seq_done) begin
			result <= seq_result;
		end
	end

	// Readable words; reserved bits and the top of the low register read zero
	assign ctrl_word = {eoc, speed, power_on, 2'h0, channel};
	assign high_word = result[9:2];
	assign low_word = {3'h0, amp_cal, slow, amp_sel, result[1:0]};

	// Read data mux for the addressed register; misaligned addresses read zero
	always @* begin
		next_rdata = 8'h00;
		if (addr_aligned) begin
			case (reg_index)
			`SAC_IDX_CTRL: begin
				next_rdata = ctrl_word;
			end
			`SAC_IDX_RES_HIGH: begin
				next_rdata = high_word;
			end
			`SAC_IDX_RES_LOW: begin
				next_rdata = low_word;
			end
			default: begin
				next_rdata = 8'h00;
			end
			endcase
		end
	end

	// Read data captured on the setup edge and held through the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= {24'h00_0000, next_rdata};
		end
	end

	// Terminal count of the divider from the speed and slow bits
	always @* begin
		if (slow) begin
			div_last = `SAC_DIV4_LAST;
		end else if (speed) begin
			div_last = `SAC_DIV1_LAST;
		end else begin
			div_last = `SAC_DIV2_LAST;
		end
	end

	// Converter clock divider, held at zero while the converter is off
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 2'h0;
		end else if (!run || conv_tick) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	assign conv_tick = run && (div_cnt >= div_last);

	// Comparator level from the analog side passes two flip-flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			cmp_meta <= comparator_high;
			cmp_sync <= cmp_meta;
		end
	end

	// Halt stops the converter; wait mode has no input and so no effect
	assign run = power_on && !halt_mode;

	// Power to converter and amplifier follows the same enable
	assign converter_power_on = run;
	assign amplifier_power = run;

	// Channel routing and amplifier controls to the analog side
	assign input_channel_select = channel;
	assign amplifier_select = amp_sel;
	assign amplifier_zero_calibrate = amp_cal;
	assign end_of_conversion = eoc;

	// Successive-approximation sequencer
	sac_sar u_sar (
		.pclk(pclk),
		.presetn(presetn),
		.tick(conv_tick),
		.run(run),
		.cmp_high(cmp_sync),
		.trial_code(trial_code),
		.sample(sample_hold),
		.done(seq_done),
		.result(seq_result)
	);

endmodule
`default_nettype wire
